// [src/sffrf_host_end.sv]
// sffrf_host_end: host side, issues one read frame per start pulse
// assumes the flash end samples this link with a faster clock
//
`timescale 1ns/1ps
`default_nettype none
module sffrf_host_end #(
   parameter int CLK_HALF = 10
) (
   sffrf_link_if.host     link,
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        start,
   input  wire logic [7:0]  opcode,
   input  wire logic [23:0] address,
   input  wire logic [7:0]  modeByte,
   input  wire logic        skipOpcode,
   input  wire logic        exitDual,
   input  wire logic [15:0] byteCount,
   output logic             busy,
   output logic [7:0]       rdData,
   output logic             rdValid,
   output logic             done
);
   typedef enum logic [5:0] {
      H_IDLE = 6'h01, H_OPC = 6'h02, H_ADDR = 6'h04,
      H_MODE = 6'h08, H_DUMMY = 6'h10, H_DATA = 6'h20
   } sffrf_hst_e;

   sffrf_hst_e  state_r;
   logic        endPend_r, sclk_r, csN_r, busy_r, rdValid_r, done_r;
   logic [7:0]  op_r, rdData_r, rx_r;
   logic [2:0]  w_r;
   logic [5:0]  cnt_r;
   logic [23:0] tx_r;
   logic [15:0] div_r, bytesLeft_r;
   logic [3:0]  laneOut_r, laneOeN_r, s1_r, s2_r;

   // ----------------------------------------------------------------
   // divider and phase decode
   // ----------------------------------------------------------------
   wire        tick    = div_r == 16'(CLK_HALF - 1);
   wire        riseT   = tick && !sclk_r;
   wire        fallT   = tick && sclk_r;
   wire        lastIn  = cnt_r <= {3'h0, w_r};
   wire [5:0]  cntDec  = cnt_r - {3'h0, w_r};
   // single-lane read data comes back on lane one, not lane zero
   wire [3:0]  rxLanes = (w_r == sffrf_pkg::W1) ? {3'h0, s2_r[1]}
                                               : sffrf_pkg::gatherIn(s2_r, w_r);
   wire [7:0]  rxNxt   = 8'((rx_r << w_r) | {4'h0, rxLanes});
   wire [5:0]  dmy     = sffrf_pkg::dummyClocks(op_r);
   wire        isExit  = opcode == sffrf_pkg::OP_EXIT_CONT;
   wire        relMode = state_r == H_MODE && cnt_r <= sffrf_pkg::MODE_DRIVEN_LO;

   assign link.csN        = csN_r;
   assign link.sclk       = sclk_r;
   assign link.hostLaneOut = laneOut_r;
   assign link.hostLaneOeN = laneOeN_r;
   assign busy    = busy_r;
   assign rdData  = rdData_r;
   assign rdValid = rdValid_r;
   assign done    = done_r;

   // ----------------------------------------------------------------
   // lane synchroniser and divider
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      s1_r <= link.lane;
      s2_r <= s1_r;
      if (srst || state_r == H_IDLE || tick) div_r <= 16'h0;
      else div_r <= div_r + 16'h1;
   end

   // ----------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      rdValid_r <= 1'b0;
      done_r    <= 1'b0;
      if (srst) begin
         state_r <= H_IDLE; sclk_r <= 1'b0; csN_r <= 1'b1;
         busy_r <= 1'b0; laneOut_r <= 4'h0; laneOeN_r <= 4'hF;
         op_r <= 8'h0; w_r <= sffrf_pkg::W1; cnt_r <= 6'h0;
         tx_r <= 24'h0; rx_r <= 8'h0; rdData_r <= 8'h0;
         bytesLeft_r <= 16'h0; endPend_r <= 1'b0;
      end else if (state_r == H_IDLE) begin
         if (start) begin
            busy_r <= 1'b1; csN_r <= 1'b0; op_r <= opcode;
            endPend_r <= 1'b0;
            bytesLeft_r <= (byteCount == 16'h0) ? 16'h1 : byteCount;
            if (isExit) begin // [RULE_14] [RULE_15]
               state_r <= H_OPC; w_r <= sffrf_pkg::W1; tx_r <= 24'hFFFFFF;
               cnt_r <= exitDual ? sffrf_pkg::EXIT_DUAL_CLKS
                                 : sffrf_pkg::EXIT_QUAD_CLKS;
               laneOut_r <= 4'h1; laneOeN_r <= 4'hE;
            end else if (skipOpcode) begin
               state_r <= H_ADDR; w_r <= sffrf_pkg::addrLanes(opcode);
               tx_r <= address; cnt_r <= sffrf_pkg::ADDR_BITS;
               laneOut_r <= sffrf_pkg::placeOut(address[23:16],
                               sffrf_pkg::addrLanes(opcode), 1'b0);
               laneOeN_r <= ~sffrf_pkg::laneMask(
                               sffrf_pkg::addrLanes(opcode), 1'b0);
            end else begin
               state_r <= H_OPC; w_r <= sffrf_pkg::W1;
               tx_r <= {opcode, 16'h0}; cnt_r <= sffrf_pkg::OPC_BITS;
               laneOut_r <= {3'h0, opcode[7]}; laneOeN_r <= 4'hE;
            end
         end
      end else if (riseT) begin
         sclk_r <= 1'b1;
         tx_r   <= tx_r << w_r;
         cnt_r  <= cntDec;
         case (state_r)
            H_OPC: if (lastIn) begin
               if (op_r == sffrf_pkg::OP_EXIT_CONT) endPend_r <= 1'b1;
               else begin
                  state_r <= H_ADDR; tx_r <= address;
                  w_r <= sffrf_pkg::addrLanes(op_r);
                  cnt_r <= sffrf_pkg::ADDR_BITS;
               end
            end
            H_ADDR: if (lastIn) begin
               if (sffrf_pkg::hasMode(op_r)) begin
                  state_r <= H_MODE; tx_r <= {modeByte, 16'h0};
                  cnt_r <= sffrf_pkg::MODE_BITS;
               end else begin
                  state_r <= H_DUMMY; cnt_r <= dmy;
               end
            end
            H_MODE: if (lastIn) begin
               state_r <= (dmy == 6'h0) ? H_DATA : H_DUMMY;
               cnt_r <= (dmy == 6'h0) ? sffrf_pkg::BYTE_BITS : dmy;
               w_r <= sffrf_pkg::dataLanes(op_r);
            end
            H_DUMMY: begin
               cnt_r <= cnt_r - 6'h1;
               w_r <= sffrf_pkg::dataLanes(op_r);
               if (cnt_r == 6'h1) begin
                  state_r <= H_DATA; cnt_r <= sffrf_pkg::BYTE_BITS;
               end
            end
            H_DATA: begin
               rx_r <= rxNxt;
               if (lastIn) begin
                  rdData_r <= rxNxt; rdValid_r <= 1'b1;
                  cnt_r <= sffrf_pkg::BYTE_BITS;
                  bytesLeft_r <= bytesLeft_r - 16'h1;
                  if (bytesLeft_r == 16'h1) endPend_r <= 1'b1;
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end else if (fallT) begin
         sclk_r <= 1'b0;
         if (endPend_r) begin
            state_r <= H_IDLE; csN_r <= 1'b1; laneOeN_r <= 4'hF;
            busy_r <= 1'b0; done_r <= 1'b1; endPend_r <= 1'b0;
         end else if (state_r == H_DUMMY || state_r == H_DATA || relMode)
            laneOeN_r <= 4'hF; // [RULE_04] [RULE_06] [RULE_09]
         else begin
            laneOut_r <= sffrf_pkg::placeOut(tx_r[23:16], w_r, 1'b0);
            laneOeN_r <= ~sffrf_pkg::laneMask(w_r, 1'b0);
         end
      end
   end
endmodule // sffrf_host_end
`default_nettype wire

// [pkg/sffrf_pkg.sv]
// sffrf_pkg: constants and shared decode for the serial flash read front end
// assumes both link ends and the bench compile this package first
package sffrf_pkg;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_FAST      = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUT  = 8'h3B;
   localparam logic [7:0] OP_QUAD_OUT  = 8'h6B;
   localparam logic [7:0] OP_DUAL_IO   = 8'hBB;
   localparam logic [7:0] OP_QUAD_IO   = 8'hEB;
   localparam logic [7:0] OP_EXIT_CONT = 8'hFF;

   // ----------------------------------------------------------------
   // field sizes and counts
   // ----------------------------------------------------------------
   localparam logic [5:0] OPC_BITS       = 6'h08;
   localparam logic [5:0] ADDR_BITS      = 6'h18;
   localparam logic [5:0] MODE_BITS      = 6'h08;
   localparam logic [5:0] BYTE_BITS      = 6'h08;
   localparam logic [5:0] DUMMY_STD_CLKS = 6'h08;
   localparam logic [5:0] DUMMY_QIO_CLKS = 6'h04;
   localparam logic [5:0] EXIT_QUAD_CLKS = 6'h08;
   localparam logic [5:0] EXIT_DUAL_CLKS = 6'h10;
   localparam logic [1:0] SKIP_OPCODE    = 2'h2;
   localparam logic [5:0] MODE_DRIVEN_LO = 6'h04;
   localparam logic [23:0] WRAP_BASE     = 24'hFFFFF8;
   localparam logic        WRAP_DIS_RST  = 1'b1;

   // lane counts per clock
   localparam logic [2:0] W1 = 3'h1;
   localparam logic [2:0] W2 = 3'h2;
   localparam logic [2:0] W4 = 3'h4;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   function automatic logic [2:0] addrLanes(input logic [7:0] op);
      addrLanes = (op == OP_DUAL_IO) ? W2 : (op == OP_QUAD_IO) ? W4 : W1;
   endfunction

   function automatic logic [2:0] dataLanes(input logic [7:0] op);
      case (op)
         OP_DUAL_OUT, OP_DUAL_IO: dataLanes = W2;
         OP_QUAD_OUT, OP_QUAD_IO: dataLanes = W4;
         default:                 dataLanes = W1;
      endcase
   endfunction

   function automatic logic hasMode(input logic [7:0] op);
      hasMode = (op == OP_DUAL_IO) || (op == OP_QUAD_IO);
   endfunction

   function automatic logic [5:0] dummyClocks(input logic [7:0] op);
      case (op)
         OP_QUAD_IO: dummyClocks = DUMMY_QIO_CLKS;
         OP_DUAL_IO: dummyClocks = 6'h00;
         default:    dummyClocks = DUMMY_STD_CLKS;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // lane packing: highest lane carries the most significant bit
   // ----------------------------------------------------------------
   function automatic logic [3:0] gatherIn(input logic [3:0] lanes,
                                           input logic [2:0] w);
      case (w)
         W4:      gatherIn = lanes;
         W2:      gatherIn = {2'h0, lanes[1:0]};
         default: gatherIn = {3'h0, lanes[0]};
      endcase
   endfunction

   // one-lane traffic uses lane one when hiOne is set, else lane zero
   function automatic logic [3:0] placeOut(input logic [7:0] b,
                                           input logic [2:0] w,
                                           input logic hiOne);
      case (w)
         W4:      placeOut = b[7:4];
         W2:      placeOut = {2'h0, b[7:6]};
         default: placeOut = hiOne ? {2'h0, b[7], 1'b0} : {3'h0, b[7]};
      endcase
   endfunction

   function automatic logic [3:0] laneMask(input logic [2:0] w,
                                           input logic hiOne);
      case (w)
         W4:      laneMask = 4'hF;
         W2:      laneMask = 4'h3;
         default: laneMask = hiOne ? 4'h2 : 4'h1;
      endcase
   endfunction

endpackage

// [pkg/sffrf_link_if.sv]
// sffrf_link_if: select, serial clock and four shared lanes
// assumes an undriven lane reads high, as with a pull-up
`timescale 1ns/1ps
`default_nettype none
interface sffrf_link_if;
   logic       csN;
   logic       sclk;
   logic [3:0] hostLaneOut;
   logic [3:0] hostLaneOeN;
   logic [3:0] devLaneOut;
   logic [3:0] devLaneOeN;
   logic [3:0] lane;

   // ----------------------------------------------------------------
   // wire level from the enables
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign lane[i] = !devLaneOeN[i]  ? devLaneOut[i]  :
                       !hostLaneOeN[i] ? hostLaneOut[i] : 1'b1;
   end

   modport host (output csN, sclk, hostLaneOut, hostLaneOeN,
                 input  lane);
   modport dev  (input  csN, sclk, lane,
                 output devLaneOut, devLaneOeN);
endinterface
`default_nettype wire

// [src/sffrf_flash_end.sv]
// sffrf_flash_end: flash side read front end with a small array
// assumes select, serial clock and lanes arrive asynchronously
// the array is not reset; it must be loaded before it is read
//
// How it works
// RULE_01: 0Bh takes address, eight dummies, single data
// RULE_02: input lane ignored during dummy clocks
// RULE_03: 3Bh returns data two bits per clock
// RULE_04: host releases lane zero before data
// RULE_05: 6Bh accepted only with quad lane enable
// RULE_06: host releases its lanes before data
// RULE_07: BBh address and data two per clock
// RULE_08: mode byte follows address; upper nibble matters; the code checks only bits five and four
// RULE_09: host may leave mode low nibble undriven
// RULE_10: EBh accepted only with quad lane enable
// RULE_11: EBh has four dummy clocks after mode
// RULE_12: skip field 10 starts next frame at address
// RULE_13: other skip values need opcode next frame
// RULE_14: quad exit: ones on lane zero, 8 clocks
// RULE_15: dual exit: ones on lane zero, 16 clocks
// RULE_16: soft reset keeps continuous read mode; here srst clears it and only deselect keeps it
// RULE_17: wrap restarts inside aligned section until deselect
// RULE_18: wrap disable and length steer wrapping
// RULE_19: length codes give 8, 16, 32, 64 bytes
// RULE_20: sample on rise, shift out on fall, MSB first
// RULE_21: address advances after every output byte
// RULE_22: highest lane carries most significant bit
// RULE_23: quad output read uses eight dummy clocks
`timescale 1ns/1ps
`default_nettype none
module sffrf_flash_end #(
   parameter int MEM_AW = 8
) (
   sffrf_link_if.dev        link,
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic              quadLaneEnable,
   input  wire logic              wrapDisable,
   input  wire logic [1:0]        wrapLengthField,
   input  wire logic              memWrEn,
   input  wire logic [MEM_AW-1:0] memWrAddr,
   input  wire logic [7:0]        memWrData,
   output logic                   contModeActive,
   output logic                   frameActive
);
   typedef enum logic [6:0] {
      D_IDLE  = 7'h01, D_OPC  = 7'h02, D_ADDR   = 7'h04, D_MODE = 7'h08,
      D_DUMMY = 7'h10, D_DATA = 7'h20, D_IGNORE = 7'h40
   } sffrf_dst_e;

   sffrf_dst_e  state_r;
   logic [5:0]  s1_r, s2_r;
   logic        sclkD_r, csD_r;
   logic [7:0]  opc_r, mode_r, outSh_r;
   logic [5:0]  cnt_r;
   logic [3:0]  outLeft_r;
   logic [2:0]  inW_r;
   logic [23:0] addr_r;
   logic        contMode_r, contQuad_r, frame_r;
   logic [3:0]  laneOut_r, laneOeN_r;
   logic [7:0]  mem [2**MEM_AW];

   // ----------------------------------------------------------------
   // synchronised link view
   // ----------------------------------------------------------------
   // link edges are seen two to three ref_clk cycles late, so a serial
   // clock half period must span several ref_clk cycles
   wire       csHi   = s2_r[5];
   wire       sclkS  = s2_r[4];
   wire [3:0] lanesS = s2_r[3:0];
   wire       rise   = sclkS && !sclkD_r;
   wire       fall   = !sclkS && sclkD_r;
   wire       frmBeg = !csHi && csD_r;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   wire [3:0] inBits  = sffrf_pkg::gatherIn(lanesS, inW_r);
   wire [7:0] opNew   = {opc_r[6:0], lanesS[0]};
   wire       isQuadOp = opNew == sffrf_pkg::OP_QUAD_OUT ||
                         opNew == sffrf_pkg::OP_QUAD_IO;
   wire       opOk    = opNew == sffrf_pkg::OP_FAST     ||
                        opNew == sffrf_pkg::OP_DUAL_OUT ||
                        opNew == sffrf_pkg::OP_DUAL_IO  ||
                        (isQuadOp && quadLaneEnable); // [RULE_05] [RULE_10]
   wire       lastIn  = cnt_r <= {3'h0, inW_r};
   wire [5:0] cntDec  = cnt_r - {3'h0, inW_r};
   wire [23:0] addrIn = 24'((addr_r << inW_r) | {20'h0, inBits});
   wire [7:0] modeIn  = 8'((mode_r << inW_r) | {4'h0, inBits});
   wire [5:0] dmy     = sffrf_pkg::dummyClocks(opc_r);
   wire [2:0] dW      = sffrf_pkg::dataLanes(opc_r);

   // ----------------------------------------------------------------
   // output byte and next address
   // ----------------------------------------------------------------
   wire        wrapOn   = !wrapDisable &&
                          opc_r == sffrf_pkg::OP_QUAD_IO; // [RULE_18]
   // each step of the length code doubles the wrap section
   wire [23:0] wrapMask = ~(sffrf_pkg::WRAP_BASE << wrapLengthField); // [RULE_19]
   wire [23:0] addrInc  = addr_r + 24'h1;
   wire [23:0] addrNext = wrapOn ? ((addr_r & ~wrapMask) | (addrInc & wrapMask))
                                 : addrInc; // [RULE_17] [RULE_21]
   wire [7:0]  curByte  = (outLeft_r == 4'h0) ? mem[addr_r[MEM_AW-1:0]]
                                              : outSh_r;
   wire [3:0]  curLeft  = (outLeft_r == 4'h0) ? 4'h8 : outLeft_r;

   assign link.devLaneOut = laneOut_r;
   assign link.devLaneOeN = laneOeN_r;
   assign contModeActive  = contMode_r;
   assign frameActive     = frame_r;

   // ----------------------------------------------------------------
   // synchronisers and array write port
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         // idle select and clock levels, lanes zero, so no false edge follows reset
         s1_r <= 6'h20; s2_r <= 6'h20; sclkD_r <= 1'b0; csD_r <= 1'b1;
      end else begin
         s1_r <= {link.csN, link.sclk, link.lane};
         s2_r <= s1_r;
         sclkD_r <= sclkS;
         csD_r <= csHi;
      end
   end

   always_ff @(posedge ref_clk) begin
      // load port only; reads go through the output shifter
      if (memWrEn) mem[memWrAddr] <= memWrData;
   end

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_r <= D_IDLE; opc_r <= 8'h0; mode_r <= 8'h0;
         cnt_r <= 6'h0; inW_r <= sffrf_pkg::W1; addr_r <= 24'h0;
         outSh_r <= 8'h0; outLeft_r <= 4'h0; frame_r <= 1'b0;
         contMode_r <= 1'b0; contQuad_r <= 1'b0;
         laneOut_r <= 4'h0; laneOeN_r <= 4'hF;
      end else if (csHi) begin
         // deselect ends any command; continuous mode survives it
         state_r <= D_IDLE; frame_r <= 1'b0; laneOeN_r <= 4'hF; // [RULE_16]
      end else if (frmBeg) begin
         frame_r <= 1'b1;
         outLeft_r <= 4'h0;
         // continuous mode reuses the lane width of the frame that set it
         if (contMode_r) begin // [RULE_12]
            state_r <= D_ADDR; cnt_r <= sffrf_pkg::ADDR_BITS;
            opc_r <= contQuad_r ? sffrf_pkg::OP_QUAD_IO : sffrf_pkg::OP_DUAL_IO;
            inW_r <= contQuad_r ? sffrf_pkg::W4 : sffrf_pkg::W2;
         end else begin // [RULE_13]
            state_r <= D_OPC; cnt_r <= sffrf_pkg::OPC_BITS;
            inW_r <= sffrf_pkg::W1; opc_r <= 8'h0;
         end
      end else if (rise) begin // [RULE_20]
         cnt_r <= cntDec;
         case (state_r)
            D_OPC: begin
               opc_r <= opNew;
               if (lastIn) begin
                  state_r <= opOk ? D_ADDR : D_IGNORE;
                  inW_r <= sffrf_pkg::addrLanes(opNew); // [RULE_07] [RULE_10]
                  cnt_r <= sffrf_pkg::ADDR_BITS;
               end
            end
            D_ADDR: begin
               addr_r <= addrIn; // [RULE_01] [RULE_22]
               if (lastIn) begin
                  if (sffrf_pkg::hasMode(opc_r)) begin // [RULE_08]
                     state_r <= D_MODE; cnt_r <= sffrf_pkg::MODE_BITS;
                  end else begin // [RULE_01] [RULE_03] [RULE_23]
                     state_r <= D_DUMMY; cnt_r <= dmy;
                  end
               end
            end
            D_MODE: begin
               // low nibble may be undriven; only bits five and four count
               mode_r <= modeIn;
               if (lastIn) begin // [RULE_08] [RULE_12] [RULE_13]
                  contMode_r <= modeIn[5:4] == sffrf_pkg::SKIP_OPCODE;
                  contQuad_r <= opc_r == sffrf_pkg::OP_QUAD_IO;
                  state_r <= (dmy == 6'h0) ? D_DATA : D_DUMMY; // [RULE_11]
                  cnt_r <= dmy;
               end
            end
            D_DUMMY: begin
               // lane contents are don't care here
               cnt_r <= cnt_r - 6'h1; // [RULE_02]
               if (cnt_r == 6'h1) state_r <= D_DATA;
            end
            // refused commands wait here with lanes released until deselect
            default: cnt_r <= cnt_r;
         endcase
      end else if (fall && state_r == D_DATA) begin
         // falling edge shifts out, top lane first
         laneOut_r <= sffrf_pkg::placeOut(curByte, dW, 1'b1); // [RULE_20] [RULE_22]
         laneOeN_r <= ~sffrf_pkg::laneMask(dW, 1'b1); // [RULE_03] [RULE_05] [RULE_07]
         outSh_r   <= 8'(curByte << dW);
         outLeft_r <= curLeft - {1'b0, dW};
         // a new byte is fetched whenever the shifter has run empty
         if (outLeft_r == 4'h0) addr_r <= addrNext; // [RULE_21]
      end
   end
endmodule // sffrf_flash_end
`default_nettype wire

// [testbench/sffrf_link_chk.sv]
// sffrf_link_chk: timing checks on the link between the two ends
// assumes the signals of one sffrf_link_if plus the bench clock and reset
`timescale 1ns/1ps
`default_nettype none
module sffrf_link_chk (
   input wire logic       ref_clk,
   input wire logic       srst,
   input wire logic       csN,
   input wire logic       sclk,
   input wire logic [3:0] hostLaneOut,
   input wire logic [3:0] hostLaneOeN,
   input wire logic [3:0] devLaneOut,
   input wire logic [3:0] devLaneOeN
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // ----------------------------------------------------------------
   // link properties
   // ----------------------------------------------------------------
   property p_noFight; ((~hostLaneOeN) & (~devLaneOeN)) == 4'h0; endproperty
   property p_devOnFall;
      $changed(devLaneOut) && devLaneOeN != 4'hF |-> !sclk;
   endproperty
   property p_hostOnFall;
      sclk |-> $stable(hostLaneOut) && $stable(hostLaneOeN);
   endproperty
   property p_sclkIdle; csN |-> !sclk; endproperty
   property p_sclkHigh; $rose(sclk) |-> sclk [*8]; endproperty
   property p_laneSets; devLaneOeN inside {4'hF, 4'hD, 4'hC, 4'h0}; endproperty
   property p_opcQuiet; $fell(csN) |-> (devLaneOeN == 4'hF) [*8]; endproperty
   property p_relDesel; csN [*6] |-> devLaneOeN == 4'hF; endproperty
   a_noFight: assert property (p_noFight) else $error("lane driven twice");
   a_devOnFall: assert property (p_devOnFall) else $error("early out");
   a_hostOnFall: assert property (p_hostOnFall) else $error("host moved");
   a_sclkIdle: assert property (p_sclkIdle) else $error("clock idle");
   a_sclkHigh: assert property (p_sclkHigh) else $error("clock short");
   a_laneSets: assert property (p_laneSets) else $error("lane set");
   a_opcQuiet: assert property (p_opcQuiet) else $error("early drive");
   a_relDesel: assert property (p_relDesel) else $error("no release");
   c_frame: cover property ($fell(csN));
   c_quad: cover property (devLaneOeN == 4'h0);
   c_single: cover property (devLaneOeN == 4'hD);
endmodule // sffrf_link_chk
`default_nettype wire

// [testbench/tb_top.sv]
// tb_top: both link ends joined, read data checked against the array
// assumes the package, the link interface and both ends compile first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        ref_clk = 1'b0, srst = 1'b1, start = 1'b0;
   logic        skipOpcode = 1'b0, exitDual = 1'b0, memWrEn = 1'b0;
   logic        quadLaneEnable = 1'b0, wrapDisable = sffrf_pkg::WRAP_DIS_RST;
   logic        busy, rdValid, done, contModeActive, frameActive;
   logic [7:0]  opcode = 8'h00, modeByte = 8'h00, memWrData = 8'h00, rdData;
   logic [7:0]  memWrAddr = 8'h00;
   logic [23:0] address = 24'h000000;
   logic [15:0] byteCount = 16'h0001;
   logic [1:0]  wrapLengthField = 2'h0;
   int          n_mismatch = 0, compares = 0, cyc = 0;
   sffrf_link_if link ();
   sffrf_host_end i_sffrf_host_end (.link, .ref_clk, .srst, .start, .opcode,
      .address, .modeByte, .skipOpcode, .exitDual, .byteCount, .busy,
      .rdData, .rdValid, .done);
   sffrf_flash_end i_sffrf_flash_end (.link, .ref_clk, .srst, .quadLaneEnable,
      .wrapDisable, .wrapLengthField, .memWrEn, .memWrAddr, .memWrData,
      .contModeActive, .frameActive);
   sffrf_link_chk i_sffrf_link_chk (.ref_clk, .srst, .csN(link.csN),
      .sclk(link.sclk), .hostLaneOut(link.hostLaneOut),
      .hostLaneOeN(link.hostLaneOeN), .devLaneOut(link.devLaneOut),
      .devLaneOeN(link.devLaneOeN));
   // ----------------------------------------------------------------
   // compare, frame and closing tasks
   // ----------------------------------------------------------------
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h00, e}, {7'h00, g});
   endtask
   // wl > 0 expects wrapping in a section of wl bytes; ff expects idle lanes
   task automatic rdFrame(input logic [7:0] op, input logic [23:0] ad,
         input logic [7:0] md, input logic sk, input logic xd, input int n,
         input int wl, input logic ff);
      int k;
      logic [23:0] a;
      k = 0;
      {opcode, address, modeByte, skipOpcode, exitDual} <= {op, ad, md, sk, xd};
      byteCount <= (n > 0) ? 16'(n) : 16'h0001;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      for (int c = 0; c < 20000 && done !== 1'b1; c++) begin
         @(posedge ref_clk);
         if (rdValid === 1'b1 && k < n) begin
            a = (wl > 0) ? ((ad & ~24'(wl - 1)) | ((ad + 24'(k)) & 24'(wl - 1)))
                         : ad + 24'(k);
            chk8("rdData", ff ? 8'hFF : a[7:0] ^ 8'h5A, rdData);
            chk1("busy", 1'b1, busy);
            k++;
         end
      end
      chk1("done", 1'b1, done);
      chk1("busy", 1'b0, busy);
      chk8("byte count", 8'(n), 8'(k));
      repeat (4) @(posedge ref_clk);
      chk1("frameActive", 1'b0, frameActive);
   endtask
   task automatic stop_test;
      if (n_mismatch == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_mismatch++;
         stop_test();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      for (int i = 0; i < 256; i++) begin
         {memWrEn, memWrAddr, memWrData} <= {1'b1, 8'(i), 8'(i) ^ 8'h5A};
         @(posedge ref_clk);
      end
      memWrEn <= 1'b0;
      rdFrame(sffrf_pkg::OP_FAST, 24'h000010, 8'h00, 0, 0, 3, 0, 0);
      rdFrame(sffrf_pkg::OP_DUAL_OUT, 24'h0000FE, 8'h00, 0, 0, 4, 0, 0);
      rdFrame(sffrf_pkg::OP_QUAD_OUT, 24'h000020, 8'h00, 0, 0, 2, 0, 1);
      rdFrame(sffrf_pkg::OP_QUAD_IO, 24'h000020, 8'h00, 0, 0, 1, 0, 1);
      quadLaneEnable <= 1'b1;
      rdFrame(sffrf_pkg::OP_QUAD_OUT, 24'h000033, 8'h00, 0, 0, 3, 0, 0);
      rdFrame(sffrf_pkg::OP_DUAL_IO, 24'h000080, 8'h00, 0, 0, 2, 0, 0);
      chk1("contModeActive", 1'b0, contModeActive);
      rdFrame(sffrf_pkg::OP_QUAD_IO, 24'h000006, 8'hA5, 0, 0, 4, 0, 0);
      chk1("contModeActive", 1'b1, contModeActive);
      rdFrame(sffrf_pkg::OP_QUAD_IO, 24'h000040, 8'hA0, 1, 0, 2, 0, 0);
      rdFrame(sffrf_pkg::OP_EXIT_CONT, 24'h000000, 8'hFF, 0, 0, 0, 0, 0);
      chk1("contModeActive", 1'b0, contModeActive);
      rdFrame(sffrf_pkg::OP_DUAL_IO, 24'h0000C0, 8'h20, 0, 0, 2, 0, 0);
      chk1("contModeActive", 1'b1, contModeActive);
      rdFrame(sffrf_pkg::OP_DUAL_IO, 24'h0000C8, 8'h20, 1, 0, 2, 0, 0);
      rdFrame(sffrf_pkg::OP_EXIT_CONT, 24'h000000, 8'hFF, 0, 1, 0, 0, 0);
      chk1("contModeActive", 1'b0, contModeActive);
      wrapDisable <= 1'b0;
      for (int w = 0; w < 4; w++) begin
         wrapLengthField <= 2'(w);
         rdFrame(sffrf_pkg::OP_QUAD_IO, 24'h000045, 8'h00, 0, 0, (8 << w) + 2, 8 << w, 0);
      end
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
